// [rtl/sdqcd_regs.svh]
// Constants for the step, direction and quadrature command decoder.
`ifndef SDQCD_REGS_SVH
`define SDQCD_REGS_SVH
`define SDQCD_POS_W 32
`define SDQCD_ADC_W 10
`define SDQCD_POS_RST 32'h0000_0000
`define SDQCD_SYNC_STAGES 2
`endif

// [rtl/sdqcd_pkg.sv]
// Types shared by the command decoder files.
package sdqcd_pkg;
  typedef enum logic [1:0] {
    SDQCD_FMT_NONE,
    SDQCD_FMT_STEP_DIR,
    SDQCD_FMT_UP_DOWN,
    SDQCD_FMT_QUAD
  } sdqcd_fmt_t;
  typedef enum logic {
    SDQCD_ANA_VEL,
    SDQCD_ANA_CUR
  } sdqcd_ana_t;
  typedef struct packed {
    logic step;
    logic cw;
  } sdqcd_step_t;
endpackage

// [rtl/sdqcd_sync.sv]
// Two-stage synchroniser for one command input.
`timescale 1ns/1ps
`default_nettype none
module sdqcd_sync
#(
  parameter int STAGES = 2
)
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic [STAGES-1:0] chain_q;

  initial
  begin
    if (STAGES < 2)
      $error("sdqcd_sync needs at least two stages");
  end

  // Only the last stage is seen outside, so the first never feeds logic.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      chain_q <= '0;
    else
      chain_q <= {chain_q[STAGES-2:0], i_async};
  end

  assign o_sync = chain_q[STAGES-1];
endmodule
`default_nettype wire

// [rtl/sdqcd_top.sv]
// Command decoder: step inputs, dedicated discrete I/O and analog select.
`timescale 1ns/1ps
`default_nettype none
`include "sdqcd_regs.svh"
module sdqcd_top
  import sdqcd_pkg::*;
#(
  parameter int POS_W = `SDQCD_POS_W,
  parameter int ADC_W = `SDQCD_ADC_W
)
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_cmd_input_a,
  input wire logic i_cmd_input_b,
  input wire sdqcd_fmt_t i_command_format_select,
  input wire logic i_analog_mode,
  input wire sdqcd_ana_t i_analog_use,
  input wire logic [ADC_W-1:0] i_analog_command_value,
  input wire logic i_drive_reset,
  input wire logic i_drive_enable,
  input wire logic i_start_on_enable_rise,
  input wire logic i_main_power_ok,
  input wire logic i_resettable_fault,
  input wire logic i_fixed_fault,
  input wire logic i_i2t_reducing,
  input wire logic i_overtemp_check_enable,
  input wire logic i_motor_overtemp_sensor,
  output logic [POS_W-1:0] o_position,
  output sdqcd_step_t o_step,
  output logic [1:0] o_general_in,
  output logic o_drive_power_on,
  output logic o_program_run,
  output logic o_program_start,
  output logic o_drive_healthy,
  output logic o_current_limit,
  output logic o_fault_latched,
  output logic o_motor_overtemp,
  output logic o_analog_valid,
  output sdqcd_ana_t o_analog_use,
  output logic [ADC_W-1:0] o_analog_cmd
);
  logic a_s;
  logic b_s;
  logic a_q;
  logic b_q;
  logic en_q;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic fmt_on;
  logic fault_any;
  logic fixed_q;
  sdqcd_step_t step_d;

  initial
  begin
    if (POS_W < 2 || ADC_W < 1)
      $error("sdqcd_top widths out of range");
  end

  // Both inputs are synchronised before any edge is looked at.
  sdqcd_sync #(.STAGES(`SDQCD_SYNC_STAGES)) u_sync_a
  (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_cmd_input_a),
    .o_sync(a_s)
  );

  sdqcd_sync #(.STAGES(`SDQCD_SYNC_STAGES)) u_sync_b
  (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_cmd_input_b),
    .o_sync(b_s)
  );

  // Previous synchronised levels for edge detection.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      a_q <= a_s;
      b_q <= b_s;
    end
  end

  assign a_rise = a_s & ~a_q;
  assign a_fall = ~a_s & a_q;
  assign b_rise = b_s & ~b_q;
  assign b_fall = ~b_s & b_q;
  assign fmt_on = (i_command_format_select != SDQCD_FMT_NONE);

  // Step decode per format; up-down counts on the falling edge ending a pulse.
  always_comb
  begin
    step_d = '0;
    unique case (i_command_format_select)
      SDQCD_FMT_NONE:
      begin
        step_d = '0;
      end
      SDQCD_FMT_STEP_DIR:
      begin
        step_d.step = b_fall;
        step_d.cw = a_s;
      end
      SDQCD_FMT_UP_DOWN:
      begin
        // A pulse while the other line is busy is ignored as illegal.
        if (a_fall && !b_s)
        begin
          step_d.step = 1'b1;
          step_d.cw = 1'b0;
        end
        else if (b_fall && !a_s)
        begin
          step_d.step = 1'b1;
          step_d.cw = 1'b1;
        end
      end
      SDQCD_FMT_QUAD:
      begin
        // Full x4 decode; a double edge in one cycle is a skipped state and dropped.
        if ((a_rise || a_fall) && !(b_rise || b_fall))
        begin
          step_d.step = 1'b1;
          step_d.cw = (a_s == b_s);
        end
        else if ((b_rise || b_fall) && !(a_rise || a_fall))
        begin
          step_d.step = 1'b1;
          step_d.cw = (a_s != b_s);
        end
      end
    endcase
  end

  // Position counter and registered step strobe.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_position <= POS_W'(`SDQCD_POS_RST);
      o_step <= '0;
    end
    else
    begin
      o_step <= step_d;
      if (step_d.step)
      begin
        if (step_d.cw)
          o_position <= o_position + POS_W'(1);
        else
          o_position <= o_position - POS_W'(1);
      end
    end
  end

  // General inputs read the lines only while no command format owns them.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_general_in <= 2'b00;
    else if (fmt_on)
      o_general_in <= 2'b00;
    else
      o_general_in <= {b_s, a_s};
  end

  // Over-temperature is a fault only when the check is switched on.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_motor_overtemp <= 1'b0;
    else
      o_motor_overtemp <= i_overtemp_check_enable & i_motor_overtemp_sensor;
  end

  // Non-resettable faults stay latched through the drive reset input.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_fault_latched <= 1'b0;
    else if (i_fixed_fault)
      o_fault_latched <= 1'b1;
    else if (i_drive_reset)
      o_fault_latched <= fixed_q | i_resettable_fault | o_motor_overtemp;
    else if (i_resettable_fault || o_motor_overtemp)
      o_fault_latched <= 1'b1;
  end

  // Separate latch for the fixed class so the drive reset cannot clear it.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      fixed_q <= 1'b0;
    else if (i_fixed_fault)
      fixed_q <= 1'b1;
  end

  assign fault_any = o_fault_latched | fixed_q | i_fixed_fault | i_resettable_fault;

  // Enable edge and program control.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      en_q <= 1'b0;
      o_program_run <= 1'b0;
      o_program_start <= 1'b0;
    end
    else
    begin
      en_q <= i_drive_enable;
      o_program_start <= i_drive_enable & ~en_q & i_start_on_enable_rise;
      if (!i_drive_enable)
        o_program_run <= 1'b0;
      else if (!en_q && i_start_on_enable_rise)
        o_program_run <= 1'b1;
    end
  end

  // Drive power is cut on the next clock edge by drive reset, by the fixed or resettable fault input or a latched fault, or by loss of enable.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_drive_power_on <= 1'b0;
    else
      o_drive_power_on <= i_drive_enable & ~i_drive_reset & ~fault_any;
  end

  // Status outputs.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_drive_healthy <= 1'b0;
      o_current_limit <= 1'b0;
    end
    else
    begin
      o_drive_healthy <= i_main_power_ok & ~fault_any;
      o_current_limit <= i_i2t_reducing;
    end
  end

  // Analog command capture; the value is held when the mode is off.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_analog_valid <= 1'b0;
      o_analog_use <= SDQCD_ANA_VEL;
      o_analog_cmd <= '0;
    end
    else
    begin
      o_analog_valid <= i_analog_mode;
      if (i_analog_mode)
      begin
        o_analog_use <= i_analog_use;
        o_analog_cmd <= i_analog_command_value;
      end
    end
  end

  // Position never moves with no format selected.
  property p_idle;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (i_command_format_select == SDQCD_FMT_NONE) |=> !o_step.step;
  endproperty
  idle_no_step_a: assert property (p_idle) else $error("step with no format");

  step_fall_b_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_command_format_select == SDQCD_FMT_STEP_DIR) && b_fall |=> o_step.step)
    else $error("falling step edge missed");

  dir_level_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_command_format_select == SDQCD_FMT_STEP_DIR) && b_fall |=> o_step.cw == $past(a_s))
    else $error("direction wrong");

  pos_move_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_step.step && o_step.cw |-> o_position == $past(o_position) + POS_W'(1))
    else $error("position not advanced");

  quad_ccw_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_command_format_select == SDQCD_FMT_QUAD) && a_rise && !b_s && !b_q
    |=> o_step.step && !o_step.cw)
    else $error("quadrature direction wrong");

  updown_ccw_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_command_format_select == SDQCD_FMT_UP_DOWN) && a_fall && !b_s
    |=> o_step.step && !o_step.cw)
    else $error("up-down step wrong");

  gp_inputs_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !fmt_on |=> o_general_in == $past({b_s, a_s}))
    else $error("general inputs wrong");

  reset_power_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_drive_reset |=> !o_drive_power_on)
    else $error("power on during reset");

  enable_stop_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !i_drive_enable |=> !o_program_run && !o_drive_power_on)
    else $error("run without enable");

  healthy_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_drive_healthy |-> $past(i_main_power_ok))
    else $error("healthy without power");

  overtemp_gate_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !i_overtemp_check_enable |=> !o_motor_overtemp)
    else $error("overtemp not ignored");
endmodule
`default_nettype wire

// [verification/sdqcd_ctrl_model.sv]
// Behavioural model of the motion controller that drives both command lines.
`timescale 1ns/1ps
`default_nettype none
module sdqcd_ctrl_model
  import sdqcd_pkg::*;
(
  input wire logic i_core_clk,
  output logic o_line_a,
  output logic o_line_b
);
  // Both lines rest low, so the first pulse starts with a clean rising edge.
  initial
  begin
    o_line_a = 1'b0;
    o_line_b = 1'b0;
  end

  // Each level stands three cycles, wider than the one-cycle minimum the decoder needs.
  task automatic hold_ab(input logic a, input logic b);
    @(negedge i_core_clk);
    o_line_a = a;
    o_line_b = b;
    repeat (2) @(negedge i_core_clk);
  endtask

  // Sends n steps, or n full quadrature cycles, and leaves both lines low.
  task automatic send(input sdqcd_fmt_t fmt, input logic cw, input int n);
    for (int i = 0; i < n; i++)
    begin
      case (fmt)
        SDQCD_FMT_UP_DOWN:
        begin
          hold_ab(!cw, cw);
          hold_ab(1'b0, 1'b0);
        end
        SDQCD_FMT_QUAD:
        begin
          hold_ab(!cw, cw);
          hold_ab(1'b1, 1'b1);
          hold_ab(cw, !cw);
          hold_ab(1'b0, 1'b0);
        end
        default:
        begin
          hold_ab(cw, 1'b1);
          hold_ab(cw, 1'b0);
        end
      endcase
    end
    hold_ab(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// [verification/sdqcd_top_bench.sv]
// Self-checking bench for the step, direction and quadrature command decoder.
`timescale 1ns/1ps
`default_nettype none
module sdqcd_top_bench
  import sdqcd_pkg::*;
  ;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_analog_mode = 1'b0, i_drive_reset = 1'b0;
  logic i_drive_enable = 1'b0, i_start_on_enable_rise = 1'b0, i_main_power_ok = 1'b0;
  logic i_resettable_fault = 1'b0, i_fixed_fault = 1'b0, i_i2t_reducing = 1'b0;
  logic i_overtemp_check_enable = 1'b0, i_motor_overtemp_sensor = 1'b0;
  logic i_cmd_input_a, i_cmd_input_b;
  sdqcd_fmt_t i_command_format_select = SDQCD_FMT_NONE;
  sdqcd_ana_t i_analog_use = SDQCD_ANA_VEL;
  logic [9:0] i_analog_command_value = 10'h000;
  logic [31:0] o_position, exp_pos = 32'h0000_0000;
  sdqcd_step_t o_step;
  sdqcd_ana_t o_analog_use;
  logic [1:0] o_general_in;
  logic [9:0] o_analog_cmd;
  logic o_drive_power_on, o_program_run, o_program_start, o_drive_healthy, o_current_limit;
  logic o_fault_latched, o_motor_overtemp, o_analog_valid;
  int error_cnt = 0, checked = 0, cw_cnt = 0, ccw_cnt = 0;

  // A 40 ns clock, the core rate.
  always #20 i_core_clk = ~i_core_clk;

  sdqcd_top DUT (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_cmd_input_a(i_cmd_input_a), .i_cmd_input_b(i_cmd_input_b),
    .i_command_format_select(i_command_format_select), .i_analog_mode(i_analog_mode),
    .i_analog_use(i_analog_use), .i_analog_command_value(i_analog_command_value),
    .i_drive_reset(i_drive_reset), .i_drive_enable(i_drive_enable),
    .i_start_on_enable_rise(i_start_on_enable_rise), .i_main_power_ok(i_main_power_ok),
    .i_resettable_fault(i_resettable_fault), .i_fixed_fault(i_fixed_fault),
    .i_i2t_reducing(i_i2t_reducing), .i_overtemp_check_enable(i_overtemp_check_enable),
    .i_motor_overtemp_sensor(i_motor_overtemp_sensor), .o_position(o_position),
    .o_step(o_step), .o_general_in(o_general_in), .o_drive_power_on(o_drive_power_on),
    .o_program_run(o_program_run), .o_program_start(o_program_start),
    .o_drive_healthy(o_drive_healthy), .o_current_limit(o_current_limit),
    .o_fault_latched(o_fault_latched), .o_motor_overtemp(o_motor_overtemp),
    .o_analog_valid(o_analog_valid), .o_analog_use(o_analog_use),
    .o_analog_cmd(o_analog_cmd));

  sdqcd_ctrl_model model (.i_core_clk(i_core_clk), .o_line_a(i_cmd_input_a),
    .o_line_b(i_cmd_input_b));

  // Step pulses are counted per direction, since one pulse lasts only one cycle.
  always @(posedge i_core_clk)
  begin
    if (o_step.step === 1'b1 && o_step.cw === 1'b1) cw_cnt <= cw_cnt + 1;
    if (o_step.step === 1'b1 && o_step.cw === 1'b0) ccw_cnt <= ccw_cnt + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Drives n units in one format and checks position and per-direction pulse counts.
  task automatic run_steps(input sdqcd_fmt_t fmt, input logic cw, input int n, input int per);
    int c0;
    int w0;
    begin
      c0 = cw_cnt;
      w0 = ccw_cnt;
      tick(1);
      i_command_format_select = fmt;
      model.send(fmt, cw, n);
      tick(3);
      exp_pos = cw ? exp_pos + n * per : exp_pos - n * per;
      chk(o_position, exp_pos);
      chk(cw_cnt - c0, cw ? n * per : 0);
      chk(ccw_cnt - w0, cw ? 0 : n * per);
    end
  endtask

  // With no format selected the lines are plain inputs and never move position.
  task automatic idle_lines();
    i_command_format_select = SDQCD_FMT_NONE;
    model.hold_ab(1'b1, 1'b0);
    tick(2);
    chk(o_general_in, 2'b01);
    model.hold_ab(1'b0, 1'b1);
    tick(2);
    chk(o_general_in, 2'b10);
    model.send(SDQCD_FMT_QUAD, 1'b1, 2);
    tick(3);
    chk(o_position, exp_pos);
    i_command_format_select = SDQCD_FMT_STEP_DIR;
    model.hold_ab(1'b1, 1'b0);
    tick(2);
    chk(o_general_in, 2'b00);
    model.hold_ab(1'b0, 1'b0);
  endtask

  // Dedicated discretes; each answers one edge after its cause.
  task automatic discretes();
    i_main_power_ok = 1'b1;
    i_start_on_enable_rise = 1'b1;
    i_drive_enable = 1'b1;
    tick(1);
    chk(o_program_start, 1'b1);
    chk(o_program_run, 1'b1);
    chk(o_drive_healthy, 1'b1);
    chk(o_drive_power_on, 1'b1);
    tick(1);
    chk(o_program_start, 1'b0);
    i_i2t_reducing = 1'b1;
    i_resettable_fault = 1'b1;
    tick(1);
    chk(o_current_limit, 1'b1);
    chk(o_drive_healthy, 1'b0);
    i_i2t_reducing = 1'b0;
    i_resettable_fault = 1'b0;
    i_motor_overtemp_sensor = 1'b1;
    tick(1);
    chk(o_current_limit, 1'b0);
    chk(o_motor_overtemp, 1'b0);
    i_drive_reset = 1'b1;
    tick(1);
    chk(o_drive_power_on, 1'b0);
    chk(o_fault_latched, 1'b0);
    i_drive_reset = 1'b0;
    i_overtemp_check_enable = 1'b1;
    tick(1);
    chk(o_motor_overtemp, 1'b1);
    i_main_power_ok = 1'b0;
    i_drive_enable = 1'b0;
    tick(1);
    chk(o_drive_healthy, 1'b0);
    chk(o_program_run, 1'b0);
    i_fixed_fault = 1'b1;
    i_motor_overtemp_sensor = 1'b0;
    tick(1);
    i_fixed_fault = 1'b0;
    i_drive_reset = 1'b1;
    tick(2);
    chk(o_fault_latched, 1'b1);
    i_analog_mode = 1'b1;
    i_analog_use = SDQCD_ANA_CUR;
    i_analog_command_value = 10'h2A5;
    tick(1);
    chk({o_analog_valid, o_analog_use, o_analog_cmd}, {2'b11, 10'h2A5});
    i_analog_use = SDQCD_ANA_VEL;
    i_analog_command_value = 10'h15A;
    tick(1);
    chk({o_analog_valid, o_analog_use, o_analog_cmd}, {2'b10, 10'h15A});
  endtask

  // Main sequence: reset, every format both ways, idle lines, then the discretes.
  initial
  begin
    tick(8);
    i_sys_rst = 1'b0;
    tick(1);
    chk(o_position, 32'h0000_0000);
    run_steps(SDQCD_FMT_STEP_DIR, 1'b1, 5, 1);
    run_steps(SDQCD_FMT_STEP_DIR, 1'b0, 3, 1);
    run_steps(SDQCD_FMT_UP_DOWN, 1'b0, 6, 1);
    run_steps(SDQCD_FMT_UP_DOWN, 1'b1, 4, 1);
    run_steps(SDQCD_FMT_QUAD, 1'b1, 2, 4);
    run_steps(SDQCD_FMT_QUAD, 1'b0, 3, 4);
    idle_lines();
    discretes();
    close_out();
  end

  // Cuts a hang short; a run that gets here is a failure.
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
